//--- clkout_pkg.sv
// Purpose : Shared constants for the square-wave clock output block.
// Assumes : 20 MHz system clock, byte-wide register port.
// Notes   : Phase increments are derived from the output rates below.
`default_nettype none
package clkout_pkg;
   // ------------------------------------------------------------
   // Clock and rates
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned F_LF0_HZ    = 32768;
   localparam int unsigned F_LF1_HZ    = 1024;
   localparam int unsigned F_LF2_HZ    = 64;
   localparam int unsigned F_LF3_HZ    = 1;
   localparam int unsigned F_HF_STEP_HZ = 8192;
   localparam logic [63:0] PHASE_ONE   = 64'h0000_0001_0000_0000;
   localparam int unsigned ACC_W       = 32;

   localparam logic [31:0] INC_LF0 = 32'((64'(F_LF0_HZ) * PHASE_ONE) / 64'(CLK_HZ));
   localparam logic [31:0] INC_LF1 = 32'((64'(F_LF1_HZ) * PHASE_ONE) / 64'(CLK_HZ));
   localparam logic [31:0] INC_LF2 = 32'((64'(F_LF2_HZ) * PHASE_ONE) / 64'(CLK_HZ));
   localparam logic [31:0] INC_LF3 = 32'((64'(F_LF3_HZ) * PHASE_ONE) / 64'(CLK_HZ));
   localparam logic [31:0] INC_HF_STEP = 32'((64'(F_HF_STEP_HZ) * PHASE_ONE) / 64'(CLK_HZ));
   // Half the phase circle: the fastest wave a 20 MHz clock can carry
   localparam logic [31:0] INC_MAX = 32'h8000_0000;

   // ------------------------------------------------------------
   // Delays
   // ------------------------------------------------------------
   localparam int unsigned T_INT_DELAY_US = 4000;
   localparam int unsigned T_OFF_DLY0_US  = 2000;
   localparam int unsigned T_OFF_DLY1_US  = 8000;
   localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
   localparam int unsigned INT_DELAY_CYC  = T_INT_DELAY_US * CYC_PER_US;
   localparam int unsigned OFF_DLY0_CYC   = T_OFF_DLY0_US * CYC_PER_US;
   localparam int unsigned OFF_DLY1_CYC   = T_OFF_DLY1_US * CYC_PER_US;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] A_FLAGS     = 8'h0e;
   localparam logic [7:0] A_CTRL2     = 8'h11;
   localparam logic [7:0] A_WAKE_SEL  = 8'h14;
   localparam logic [7:0] A_EVI_CTRL  = 8'h15;
   localparam logic [7:0] A_PMU       = 8'hc0;
   localparam logic [7:0] A_CLKOUT1   = 8'hc2;
   localparam logic [7:0] A_CLKOUT2   = 8'hc3;

   localparam int unsigned B_WAVE_FLAG  = 1;  // 0Eh
   localparam int unsigned B_IRQ_WAVE   = 6;  // 11h
   localparam int unsigned B_OFF_SEL    = 7;  // 14h
   localparam int unsigned B_INT_DLY    = 6;  // 14h
   localparam int unsigned SRC_N        = 6;  // 14h [5:0] wake sources
   localparam int unsigned B_EVT_SRC    = 5;  // 14h source fed by the event pin
   localparam int unsigned B_OFF_EN     = 7;  // 15h
   localparam int unsigned B_EVT_HIGH   = 6;  // 15h active edge of event pin
   localparam int unsigned B_NORM_DIS   = 6;  // C0h
   localparam int unsigned B_HF_SEL     = 7;  // C3h
   localparam int unsigned B_FD_HI      = 6;  // C3h divider field
   localparam int unsigned B_FD_LO      = 5;
   localparam int unsigned B_HFD_HI     = 4;  // C3h multiplier upper bits

   localparam logic [7:0] RST_REG   = 8'h00;
   localparam logic [31:0] RST_INC  = INC_LF0;
endpackage
`default_nettype wire

//--- square_wave_nco.sv
// Purpose : Phase accumulator producing a 50 % square wave.
// Assumes : Increment is at most half the phase circle.
// Notes   : low_edge_o pulses in the cycle the wave has just gone low.
`timescale 1ns/1ps
`default_nettype none
module square_wave_nco (
   input  wire logic        clk_i,      // System clock
   input  wire logic        sys_rst_i,  // Synchronous reset, active high
   input  wire logic [31:0] inc_i,      // Phase step per clock
   output logic             wave_o,     // Square wave, registered
   output logic             low_edge_o  // Falling-edge pulse, registered
);
   import clkout_pkg::*;

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             fall;
   } nco_t;

   nco_t st_q;
   nco_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.acc  = st_q.acc + inc_i;
      st_d.fall = st_q.acc[ACC_W-1] & ~st_d.acc[ACC_W-1];
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wave_o     = st_q.acc[ACC_W-1];
   assign low_edge_o = st_q.fall;
endmodule
`default_nettype wire

//--- clock_output_control.sv
// Purpose : Square-wave clock output with normal and event-driven enable,
//           interrupt delay after start and switch-off delay after STOP.
// Assumes : Register port is decoded from the serial bus elsewhere;
//           all inputs are synchronous to clk_i.
// Notes   : Rates above 10 MHz are clamped; the wave saturates at clk_i / 2.
`timescale 1ns/1ps
`default_nettype none
module clock_output_control #(
   parameter int unsigned INT_DLY_CYC  = clkout_pkg::INT_DELAY_CYC, // Interrupt delay
   parameter int unsigned OFF_DLY0_CYC = clkout_pkg::OFF_DLY0_CYC,  // Off delay, select 0
   parameter int unsigned OFF_DLY1_CYC = clkout_pkg::OFF_DLY1_CYC   // Off delay, select 1
) (
   input  wire logic                          clk_i,            // 20 MHz clock
   input  wire logic                          sys_rst_i,        // Sync reset, high
   input  wire logic                          reg_wr_i,         // Register write strobe
   input  wire logic                          reg_rd_i,         // Register read strobe
   input  wire logic [7:0]                    reg_addr_i,       // Register address
   input  wire logic [7:0]                    reg_wdata_i,      // Write data
   input  wire logic                          i2c_stop_i,       // Bus STOP seen, pulse
   input  wire logic                          battery_supply_state, // On backup supply
   input  wire logic                          event_input_pin,  // External event level
   input  wire logic [clkout_pkg::SRC_N-2:0]  irq_src_i,        // Other sources, pulses
   output logic [7:0]                         reg_rdata_o,      // Read data
   output logic                               square_wave_pin_o, // Clock output pin
   output logic                               irq_pin_n_o,      // Interrupt pin level
   output logic                               irq_pin_oe_o      // Interrupt pin drive
);
   import clkout_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  ctrl2;
      logic [7:0]  wake_sel;
      logic [7:0]  evi_ctrl;
      logic [7:0]  pmu;
      logic [7:0]  clkout1;
      logic [7:0]  clkout2;
      logic        flag;
      logic        evt_prev;
      logic        gate;
      logic [31:0] inc;
      logic [31:0] int_cnt;
      logic [31:0] off_cnt;
      logic        irq_act;
      logic        pin;
      logic        irq_n;
      logic [7:0]  rdata;
   } ctl_t;

   ctl_t        st_q;
   ctl_t        st_d;
   logic        wave;
   logic        low_edge;
   logic        evt_edge;
   logic [SRC_N-1:0] src_hit;
   logic        set_flag;
   logic        clr_flag;
   logic        want;
   logic [12:0] high_freq_multiplier;
   logic [47:0] hf_prod;
   logic [31:0] inc_sel;

   square_wave_nco u_nco (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .inc_i      (st_q.inc),
      .wave_o     (wave),
      .low_edge_o (low_edge)
   );

   // ------------------------------------------------------------
   // Rate selection
   // ------------------------------------------------------------
   assign high_freq_multiplier     = {st_q.clkout2[B_HFD_HI:0], st_q.clkout1};
   assign hf_prod = 48'(high_freq_multiplier) * 48'(INC_HF_STEP) + 48'(INC_HF_STEP);

   always_comb begin
      inc_sel = INC_LF0;
      if (st_q.clkout2[B_HF_SEL]) begin
         // Saturate: past clk_i / 2 the accumulator cannot make a wave
         inc_sel = (hf_prod > 48'(INC_MAX)) ? INC_MAX : hf_prod[31:0];
      end else begin
         case (st_q.clkout2[B_FD_HI:B_FD_LO])
            2'b00:   inc_sel = INC_LF0;
            2'b01:   inc_sel = INC_LF1;
            2'b10:   inc_sel = INC_LF2;
            2'b11:   inc_sel = INC_LF3;
            default: inc_sel = INC_LF0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Wake events
   // ------------------------------------------------------------
   // Event pin is watched on battery as well; its edge is a wake source
   assign evt_edge = st_q.evi_ctrl[B_EVT_HIGH] ? (event_input_pin & ~st_q.evt_prev)
                                               : (~event_input_pin & st_q.evt_prev);
   assign src_hit  = {evt_edge, irq_src_i} & st_q.wake_sel[SRC_N-1:0];
   assign set_flag = st_q.ctrl2[B_IRQ_WAVE] & (|src_hit);
   assign clr_flag = reg_wr_i & (reg_addr_i == A_FLAGS) & ~reg_wdata_i[B_WAVE_FLAG];
   // A running switch-off delay keeps an already running wave alive
   assign want     = ~st_q.pmu[B_NORM_DIS] | st_q.flag
                     | ((st_q.off_cnt != 32'h0000_0000) & st_q.gate);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d          = st_q;
      st_d.evt_prev = event_input_pin;

      if (reg_wr_i) begin
         case (reg_addr_i)
            A_CTRL2:    st_d.ctrl2    = reg_wdata_i;
            A_WAKE_SEL: st_d.wake_sel = reg_wdata_i;
            A_EVI_CTRL: st_d.evi_ctrl = reg_wdata_i;
            A_PMU:      st_d.pmu      = reg_wdata_i;
            A_CLKOUT1:  st_d.clkout1  = reg_wdata_i;
            A_CLKOUT2:  st_d.clkout2  = reg_wdata_i;
            default:    st_d.ctrl2    = st_q.ctrl2;
         endcase
      end

      // Set wins over a clear in the same cycle
      if (set_flag) begin
         st_d.flag = 1'b1;
      end else if (clr_flag) begin
         st_d.flag = 1'b0;
      end

      // Gate moves only while the wave is low, so no pulse is cut short
      if (!wave) begin
         st_d.gate = want;
      end

      // New rate is loaded just after a falling edge: the wave stays low
      if (low_edge) begin
         st_d.inc = inc_sel;
      end

      if (i2c_stop_i && st_q.evi_ctrl[B_OFF_EN]) begin
         st_d.off_cnt = st_q.wake_sel[B_OFF_SEL] ? OFF_DLY1_CYC : OFF_DLY0_CYC;
      end else if (st_q.off_cnt != 32'h0000_0000) begin
         st_d.off_cnt = st_q.off_cnt - 32'h0000_0001;
      end

      // Delay counts from the moment the gated wave is running
      if (!st_q.flag || !st_q.gate) begin
         st_d.int_cnt = 32'h0000_0000;
      end else if (st_q.int_cnt != INT_DLY_CYC) begin
         st_d.int_cnt = st_q.int_cnt + 32'h0000_0001;
      end
      st_d.irq_act = st_q.flag & (~st_q.wake_sel[B_INT_DLY]
                     | (st_q.int_cnt == INT_DLY_CYC));
      // Interrupt path ignores the supply state
      st_d.irq_n   = ~st_d.irq_act;

      st_d.pin = wave & st_q.gate & ~battery_supply_state;

      if (reg_rd_i) begin
         case (reg_addr_i)
            A_FLAGS:    st_d.rdata = {6'h00, st_q.flag, 1'b0};
            A_CTRL2:    st_d.rdata = st_q.ctrl2;
            A_WAKE_SEL: st_d.rdata = st_q.wake_sel;
            A_EVI_CTRL: st_d.rdata = st_q.evi_ctrl;
            A_PMU:      st_d.rdata = st_q.pmu;
            A_CLKOUT1:  st_d.rdata = st_q.clkout1;
            A_CLKOUT2:  st_d.rdata = st_q.clkout2;
            default:    st_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_q       <= '0;
         st_q.inc   <= RST_INC;
         st_q.irq_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_o       = st_q.rdata;
   assign square_wave_pin_o = st_q.pin;
   assign irq_pin_n_o       = st_q.irq_n;
   assign irq_pin_oe_o      = st_q.irq_act;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_batt_pin_low: assert property (battery_supply_state |=> !square_wave_pin_o)
      else $error("pin not low on battery supply");
   a_pin_needs_gate: assert property (!st_q.gate |=> !square_wave_pin_o)
      else $error("pin toggles with gate closed");
   a_normal_opens: assert property (!st_q.pmu[B_NORM_DIS] && !wave |=> st_q.gate)
      else $error("normal path did not open gate");
   a_irq_path_opens: assert property (st_q.flag && !wave |=> st_q.gate)
      else $error("event path did not open gate");
   a_event_sets: assert property (set_flag |=> st_q.flag)
      else $error("masked event did not set flag");
   a_flag_holds: assert property (st_q.flag && !clr_flag |=> st_q.flag)
      else $error("flag dropped without clear");
   a_clear_drops: assert property (clr_flag && !set_flag |=> !st_q.flag)
      else $error("flag clear ignored");
   a_gate_sync: assert property (st_q.gate != $past(st_q.gate) |-> !$past(wave))
      else $error("gate changed while wave high");
   a_rate_at_low: assert property (st_q.inc != $past(st_q.inc) |-> $past(low_edge))
      else $error("rate changed away from falling edge");
   a_irq_delay: assert property (st_q.wake_sel[B_INT_DLY] && st_q.int_cnt != INT_DLY_CYC
                                 |=> !irq_pin_oe_o)
      else $error("interrupt asserted before delay");
   a_irq_polarity: assert property (irq_pin_oe_o == !irq_pin_n_o)
      else $error("interrupt pin level and drive disagree");
   a_off_load: assert property (i2c_stop_i && st_q.evi_ctrl[B_OFF_EN] && !st_q.wake_sel[B_OFF_SEL]
                                |=> st_q.off_cnt == OFF_DLY0_CYC)
      else $error("switch-off delay not loaded");
   a_hf_rate: assert property (low_edge && st_q.clkout2[B_HF_SEL] && high_freq_multiplier == 13'h0000
                               |=> st_q.inc == INC_HF_STEP)
      else $error("lowest HF step wrong");
   a_event_src: assert property (st_q.ctrl2[B_IRQ_WAVE] && st_q.wake_sel[B_EVT_SRC] && evt_edge
                                 |=> st_q.flag)
      else $error("event pin did not start wave");

   c_event_wake: cover property (set_flag ##1 st_q.flag ##[1:200] square_wave_pin_o);
   c_stop_delay: cover property (i2c_stop_i && st_q.evi_ctrl[B_OFF_EN]);
   c_hf_switch: cover property (low_edge && st_q.clkout2[B_HF_SEL] && st_q.inc != inc_sel);
   c_irq_delayed: cover property (st_q.wake_sel[B_INT_DLY] && irq_pin_oe_o);
endmodule
`default_nettype wire

//--- host_mcu_model.sv
// Purpose : Host-side model woken by the clock output.
// Assumes : The interrupt line has a pull-up on the board.
// Notes   : Counts rising edges of the clock output pin.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
   input  wire logic        clk_i,      // System clock
   input  wire logic        clr_i,      // Clear edge count
   input  wire logic        wave_i,     // Clock output pin
   input  wire logic        irq_n_i,    // Interrupt drive level
   input  wire logic        irq_oe_i,   // Interrupt drive enable
   output logic             irq_line_o, // Resolved interrupt line
   output logic [15:0]      rise_cnt_o  // Rising edges seen
);
   logic wave_q;
   // Open drain never drives high; a released line rests at the pull-up
   assign irq_line_o = (irq_oe_i && !irq_n_i) ? 1'b0 : 1'b1;
   always_ff @(posedge clk_i) begin
      wave_q <= wave_i;
      if (clr_i) begin
         rise_cnt_o <= 16'h0000;
      end else if (wave_i && !wave_q) begin
         rise_cnt_o <= rise_cnt_o + 16'h0001;
      end
   end
endmodule
`default_nettype wire

//--- clock_output_control_tb.sv
// Purpose : Self-checking bench for the clock output block.
// Assumes : Delays shortened to 20/10/30 cycles.
// Notes   : Expected read data is noted in a queue and checked by a monitor.
`timescale 1ns/1ps
`default_nettype none
module clock_output_control_tb;
   import clkout_pkg::*;
   localparam int INT_DLY = 20;
   logic        clk_i, rst, wr_s, rd_s, stop, batt, evt, clr, rd_d;
   logic        pin, irq_n, irq_oe, irq_line;
   logic [7:0]  addr, wdata, rdata, rnd;
   logic [4:0]  src;
   logic [15:0] cnt;
   logic [7:0]  exp_q [$];
   logic [7:0]  regs [7] = '{A_FLAGS, A_CTRL2, A_WAKE_SEL, A_EVI_CTRL, A_PMU, A_CLKOUT1,
                              A_CLKOUT2};
   int          miscompares, n_tests, c, e;
   integer      seed;

   clock_output_control #(.INT_DLY_CYC(20), .OFF_DLY0_CYC(10), .OFF_DLY1_CYC(30)) u_dut (
      .clk_i               (clk_i),
      .sys_rst_i           (rst),
      .reg_wr_i            (wr_s),
      .reg_rd_i            (rd_s),
      .reg_addr_i          (addr),
      .reg_wdata_i         (wdata),
      .i2c_stop_i          (stop),
      .battery_supply_state(batt),
      .event_input_pin     (evt),
      .irq_src_i           (src),
      .reg_rdata_o         (rdata),
      .square_wave_pin_o   (pin),
      .irq_pin_n_o         (irq_n),
      .irq_pin_oe_o        (irq_oe)
   );
   host_mcu_model u_host (.clk_i(clk_i), .clr_i(clr), .wave_i(pin), .irq_n_i(irq_n),
      .irq_oe_i(irq_oe), .irq_line_o(irq_line), .rise_cnt_o(cnt));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic near(input logic [15:0] v, input int x);
      check(32'(int'(v) >= x - 1 && int'(v) <= x + 1), 32'h1);
   endtask
   task automatic conclude();
      $display("TB: %0d compares, %0d mismatches", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_s <= w;
      rd_s <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      access(1'b0, a, 8'h00);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clk_i);
      src <= v;
      @(posedge clk_i);
      src <= 5'h00;
   endtask
   task automatic measure(input int n);
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_irq(input int lim);
      c = 0;
      while (irq_line !== 1'b0) begin
         @(posedge clk_i);
         c++;
         if (c > lim) begin
            miscompares++;
            conclude();
         end
      end
   endtask
   // Read data is valid one cycle after the read is taken
   always @(posedge clk_i) begin
      rd_d <= rd_s;
      if (rd_d && exp_q.size() > 0) begin
         check({24'h0, rdata}, {24'h0, exp_q.pop_front()});
      end
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      seed = 32'h0dc0a0bc;
      {wr_s, rd_s, stop, batt, evt, clr, rd_d, addr, wdata, src} = '0;
      rst = 1'b1;
      repeat (2) @(posedge clk_i);
      rst <= 1'b0;
      foreach (regs[i]) rd(regs[i], 8'h00);
      rnd = 8'($random(seed));
      wr(8'h20, rnd);
      rd(8'h20, 8'h00);
      wr(A_WAKE_SEL, rnd);
      rd(A_WAKE_SEL, rnd);
      wr(A_WAKE_SEL, 8'h00);
      $display("TB: register test done");
      measure(10000);
      near(cnt, int'(64'(10000) * F_LF0_HZ / CLK_HZ));
      rnd = 8'h10 + 8'($random(seed) & 127);
      wr(A_CLKOUT1, rnd);
      wr(A_CLKOUT2, 8'h80);
      // New rate waits for a falling edge, up to one slow period away
      repeat (700) @(posedge clk_i);
      measure(10000);
      e = int'(64'(10000) * (64'(rnd) + 1) * F_HF_STEP_HZ / CLK_HZ);
      near(cnt, e);
      $display("TB: rate test done");
      wr(A_CLKOUT1, 8'hff);
      e = int'(64'(500) * 256 * F_HF_STEP_HZ / CLK_HZ);
      wr(A_PMU, 8'h40);
      repeat (50) @(posedge clk_i);
      measure(500);
      check(32'(cnt), 32'h0);
      wr(A_CTRL2, 8'h40);
      wr(A_WAKE_SEL, 8'h01);
      pulse(5'h01);
      wait_irq(5);
      rd(A_FLAGS, 8'h02);
      repeat (30) @(posedge clk_i);
      measure(500);
      near(cnt, e);
      wr(A_CTRL2, 8'h00);
      measure(500);
      near(cnt, e);
      wr(A_FLAGS, 8'h00);
      repeat (20) @(posedge clk_i);
      measure(500);
      check(32'(cnt), 32'h0);
      check(32'(irq_line), 32'h1);
      $display("TB: event wave test done");
      wr(A_CTRL2, 8'h40);
      wr(A_WAKE_SEL, 8'h41);
      pulse(5'h01);
      wait_irq(300);
      check(32'(c >= INT_DLY && c <= INT_DLY + 20), 32'h1);
      wr(A_FLAGS, 8'h00);
      wr(A_EVI_CTRL, 8'h40);
      wr(A_WAKE_SEL, 8'h20);
      @(posedge clk_i);
      batt <= 1'b1;
      evt <= 1'b1;
      wait_irq(5);
      measure(500);
      check(32'(cnt), 32'h0);
      @(posedge clk_i);
      batt <= 1'b0;
      repeat (30) @(posedge clk_i);
      measure(500);
      near(cnt, e);
      @(posedge clk_i);
      evt <= 1'b0;
      wr(A_FLAGS, 8'h00);
      $display("TB: delay and battery test done");
      wr(A_CTRL2, 8'h00);
      wr(A_EVI_CTRL, 8'hc0);
      // Both switch-off delay selections, short one first
      for (int k = 0; k < 2; k++) begin
         wr(A_WAKE_SEL, (k == 1) ? 8'h80 : 8'h00);
         wr(A_PMU, 8'h00);
         repeat (30) @(posedge clk_i);
         // Disable and STOP land together so the gate is still open
         @(posedge clk_i);
         wr_s <= 1'b1;
         addr <= A_PMU;
         wdata <= 8'h40;
         stop <= 1'b1;
         @(posedge clk_i);
         wr_s <= 1'b0;
         stop <= 1'b0;
         measure(25);
         if (k == 1) begin
            check(32'(cnt >= 16'h0002), 32'h1);
         end
         repeat (60) @(posedge clk_i);
         measure(300);
         check(32'(cnt), 32'h0);
      end
      $display("TB: stop delay test done");
      wr(A_PMU, 8'h00);
      wr(A_CLKOUT1, 8'h00);
      repeat (20) @(posedge clk_i);
      measure(10000);
      near(cnt, int'(64'(10000) * F_HF_STEP_HZ / CLK_HZ));
      wr(A_CLKOUT2, 8'h20);
      repeat (2500) @(posedge clk_i);
      measure(40000);
      near(cnt, int'(64'(40000) * F_LF1_HZ / CLK_HZ));
      $display("TB: low rate test done");
      repeat (3) @(posedge clk_i);
      conclude();
   end
endmodule
`default_nettype wire
